// ==== bank_ctrl_pkg.sv ====
// Constants for the bank and input select control block.
// Assumes a single 50 MHz clock and an active-low asynchronous reset.
// Notes on behaviour
// - Bank inputs form bank number, input1 LSB
// - Bank setting 0-9, default 9; 0-7 direct
// - Bank setting 8 enables external input functions
// - Input one: ignored 0-7, bank bit 8-9
// - Input two: teach 0-8, bank bit 9
// - Input three: sync if trigger 0-3, else bank/ignored
// - Rate default 57600; codes 1-5 select rates
// - Measurement suspended while host transfer active
// - Exit held 1.5 s starts auto gain
// - Set held 1.5 s commits setting
// - Both keys at power-up restore factory presets
// - Edge-count teach copies taught counts to thresholds
// - Position teach gives thresholds plus/minus 5 percent
// - Exit in operation menu returns to main
// - Host frame: 8 data, no parity, 1 stop
// - Rate code 0 turns link off, monitor on
package bank_ctrl_pkg;
    localparam int CLK_HZ = 50000000;
    localparam logic [3:0] BANK_DEFAULT = 4'h9;
    localparam logic [3:0] BANK_EXT = 4'h8;
    localparam logic [3:0] BANK_MAX = 4'h9;
    localparam logic [2:0] TRIG_NONE = 3'h4;
    localparam logic [2:0] RATE_DEFAULT = 3'h5;
    localparam logic [2:0] RATE_MAX = 3'h5;
    localparam int DATA_BITS = 8;
    localparam int STOP_BITS = 1;
    localparam int HOLD_MS = 1500;
    localparam int HOLD_CYCLES = (CLK_HZ / 1000) * HOLD_MS;
    localparam int FILTER_CYCLES = 16;
    localparam int RATE_4800 = 4800;
    localparam int RATE_9600 = 9600;
    localparam int RATE_19200 = 19200;
    localparam int RATE_38400 = 38400;
    localparam int RATE_57600 = 57600;
    localparam int PCT_NUM = 5;
    localparam int PCT_DEN = 100;
    localparam int ALT_CYCLES = CLK_HZ / 4;
    typedef enum logic [3:0] {
        MENU_MAIN = 4'h1,
        MENU_OPER = 4'h2,
        MENU_AUTO = 4'h4,
        MENU_INIT = 4'h8
    } menu_t;
endpackage

// ==== bank_input_select_control.sv ====
// Bank select, wired input decode, key handling and teach threshold logic.
// Assumes keys and wired inputs are asynchronous and active high here;
// the gain search itself reports completion on gain_done_in.
`timescale 1ns/1ps
`default_nettype none
module bank_input_select_control
    import bank_ctrl_pkg::*;
#(
    parameter int HOLD_COUNT = HOLD_CYCLES,
    parameter int ALT_COUNT = ALT_CYCLES,
    parameter int VAL_W = 16
) (
    // Clock and reset
    input wire logic clock_in,
    input wire logic nrst_in,
    // Wired inputs
    input wire logic [2:0] wired_in,
    // Stored settings
    input wire logic [3:0] bank_setting_in,
    input wire logic [2:0] trigger_select_in,
    input wire logic [2:0] serial_rate_select_in,
    input wire logic host_transfer_mode_in,
    input wire logic transfer_done_in,
    // Keys
    input wire logic exit_key_in,
    input wire logic set_key_in,
    input wire logic oper_menu_in,
    input wire logic gain_done_in,
    // Teaching
    input wire logic teach_in,
    input wire logic edge_mode_in,
    input wire logic [3*VAL_W-1:0] taught_count_in,
    input wire logic [VAL_W-1:0] measured_in,
    // Decoded outputs
    output logic [2:0] active_bank_out,
    output logic ext_teach_out,
    output logic sync_out,
    output logic sync_valid_out,
    output logic [3:0] bank_setting_out,
    // Host link
    output logic link_enable_out,
    output logic monitor_enable_out,
    output logic [31:0] baud_rate_out,
    output logic [3:0] frame_data_bits_out,
    output logic [1:0] frame_stop_bits_out,
    output logic measure_enable_out,
    // Keys and menu
    output logic [3:0] menu_state_out,
    output logic commit_out,
    output logic auto_gain_out,
    output logic [1:0] indicator_out,
    output logic factory_restore_out,
    // Thresholds
    output logic [3*VAL_W-1:0] upper_thr_out,
    output logic [3*VAL_W-1:0] lower_thr_out
);
    // Refuse sizes the counters and threshold arithmetic cannot serve
    if (HOLD_COUNT < 1 || ALT_COUNT < 1 || VAL_W < 8 || VAL_W > 32) begin : g_bad_param
        $error("bank_input_select_control: bad parameter");
    end

    // ------------------------------------------------------------
    // Input synchronisers and filters
    // ------------------------------------------------------------
    logic [2:0] s1_q, s2_q, s3_q, stable_q;
    logic [4:0] keys_s1_q, keys_s2_q, keys_s3_q;
    logic [7:0] flt_q [3];
    logic set_k, exit_k;
    assign set_k = keys_s2_q[0] & keys_s3_q[0];
    assign exit_k = keys_s2_q[1] & keys_s3_q[1];

    always_ff @(posedge clock_in or negedge nrst_in) begin
        if (!nrst_in) begin
            s1_q <= 3'h0;
            s2_q <= 3'h0;
            s3_q <= 3'h0;
            keys_s1_q <= 5'h00;
            keys_s2_q <= 5'h00;
            keys_s3_q <= 5'h00;
        end else begin
            s1_q <= wired_in;
            s2_q <= s1_q;
            s3_q <= s2_q;
            keys_s1_q <= {3'h0, exit_key_in, set_key_in};
            keys_s2_q <= keys_s1_q;
            keys_s3_q <= keys_s2_q;
        end
    end

    // Filter: value must hold for FILTER_CYCLES before decoding sees it
    for (genvar i = 0; i < 3; i++) begin : g_flt
        always_ff @(posedge clock_in or negedge nrst_in) begin
            if (!nrst_in) begin
                flt_q[i] <= 8'h00;
                stable_q[i] <= 1'b0;
            end else if (s2_q[i] != s3_q[i] || s3_q[i] == stable_q[i]) begin
                flt_q[i] <= 8'h00;
            end else if (flt_q[i] == 8'(FILTER_CYCLES - 1)) begin
                flt_q[i] <= 8'h00;
                stable_q[i] <= s3_q[i];
            end else begin
                flt_q[i] <= flt_q[i] + 8'h01;
            end
        end
    end

    // ------------------------------------------------------------
    // Input function decode
    // ------------------------------------------------------------
    logic [3:0] bank_eff;
    logic direct_bank, sync_used, in1_bank, in2_bank, in3_bank;
    logic [2:0] bank_d;
    // Out-of-range settings fall back to the default
    assign bank_eff = (bank_setting_in > BANK_MAX) ? BANK_DEFAULT : bank_setting_in;
    assign direct_bank = bank_eff < BANK_EXT;
    assign sync_used = trigger_select_in < TRIG_NONE;
    assign in1_bank = !direct_bank;
    assign in2_bank = bank_eff == BANK_DEFAULT;
    assign in3_bank = !direct_bank && !sync_used;
    // Unused bank bits read as zero
    assign bank_d = direct_bank ? bank_eff[2:0] :
        {in3_bank & stable_q[2], in2_bank & stable_q[1], in1_bank & stable_q[0]};

    // ------------------------------------------------------------
    // Host link rate
    // ------------------------------------------------------------
    function automatic logic [31:0] rate_of(input logic [2:0] code);
        case (code)
            3'h1: rate_of = 32'(RATE_4800);
            3'h2: rate_of = 32'(RATE_9600);
            3'h3: rate_of = 32'(RATE_19200);
            3'h4: rate_of = 32'(RATE_38400);
            default: rate_of = 32'(RATE_57600);
        endcase
    endfunction
    logic [2:0] rate_code;
    assign rate_code = (serial_rate_select_in > RATE_MAX) ? RATE_DEFAULT : serial_rate_select_in;

    // ------------------------------------------------------------
    // Key hold timers and menu state
    // ------------------------------------------------------------
    menu_t menu_q, menu_d;
    logic [31:0] set_cnt_q, exit_cnt_q, alt_cnt_q;
    logic set_long, exit_long, boot_q, transfer_q;
    assign set_long = set_k && set_cnt_q == 32'(HOLD_COUNT - 1);
    assign exit_long = exit_k && exit_cnt_q == 32'(HOLD_COUNT - 1);

    always_comb begin
        menu_d = menu_q;
        case (menu_q)
            MENU_MAIN: begin
                if (exit_long) begin
                    menu_d = MENU_AUTO;
                end else if (oper_menu_in) begin
                    menu_d = MENU_OPER;
                end
            end
            MENU_OPER: begin
                if (exit_k) begin
                    menu_d = MENU_MAIN;
                end
            end
            MENU_AUTO: begin
                if (gain_done_in) begin
                    menu_d = MENU_MAIN;
                end
            end
            MENU_INIT: begin
                menu_d = MENU_MAIN;
            end
            default: menu_d = MENU_MAIN;
        endcase
        // Power-up restore check happens once, after synchronisers settle
        if (boot_q && set_k && exit_k) begin
            menu_d = MENU_INIT;
        end
    end

    always_ff @(posedge clock_in or negedge nrst_in) begin
        if (!nrst_in) begin
            set_cnt_q <= 32'h0;
            exit_cnt_q <= 32'h0;
        end else begin
            // Counters saturate so one long press commits once
            set_cnt_q <= !set_k ? 32'h0 : (set_long ? set_cnt_q + 32'h1 :
                (set_cnt_q >= 32'(HOLD_COUNT) ? set_cnt_q : set_cnt_q + 32'h1));
            exit_cnt_q <= !exit_k ? 32'h0 :
                (exit_cnt_q >= 32'(HOLD_COUNT) ? exit_cnt_q : exit_cnt_q + 32'h1);
        end
    end

    logic [3:0] boot_cnt_q;
    always_ff @(posedge clock_in or negedge nrst_in) begin
        if (!nrst_in) begin
            boot_cnt_q <= 4'h0;
            boot_q <= 1'b0;
            menu_q <= MENU_MAIN;
            alt_cnt_q <= 32'h0;
            transfer_q <= 1'b0;
        end else begin
            boot_cnt_q <= (boot_cnt_q == 4'hF) ? boot_cnt_q : boot_cnt_q + 4'h1;
            boot_q <= boot_cnt_q == 4'h4;
            menu_q <= menu_d;
            alt_cnt_q <= (menu_q != MENU_AUTO || alt_cnt_q == 32'(2 * ALT_COUNT - 1)) ?
                32'h0 : alt_cnt_q + 32'h1;
            // Transfer runs from mode entry until the host reports completion or the mode is left
            if (host_transfer_mode_in && !transfer_done_in) begin
                transfer_q <= 1'b1;
            end else if (transfer_done_in || !host_transfer_mode_in) begin
                transfer_q <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // Teach thresholds
    // ------------------------------------------------------------
    logic [VAL_W-1:0] margin;
    logic [VAL_W+7:0] prod;
    assign prod = {8'h00, measured_in} * (VAL_W + 8)'(PCT_NUM);
    assign margin = VAL_W'(prod / (VAL_W + 8)'(PCT_DEN));

    // ------------------------------------------------------------
    // Output registers
    // ------------------------------------------------------------
    always_ff @(posedge clock_in or negedge nrst_in) begin
        if (!nrst_in) begin
            active_bank_out <= 3'h0;
            ext_teach_out <= 1'b0;
            sync_out <= 1'b0;
            sync_valid_out <= 1'b0;
            bank_setting_out <= BANK_DEFAULT;
            link_enable_out <= 1'b1;
            monitor_enable_out <= 1'b0;
            baud_rate_out <= 32'(RATE_57600);
            frame_data_bits_out <= 4'(DATA_BITS);
            frame_stop_bits_out <= 2'(STOP_BITS);
            measure_enable_out <= 1'b0;
            menu_state_out <= 4'h1;
            commit_out <= 1'b0;
            auto_gain_out <= 1'b0;
            indicator_out <= 2'h0;
            factory_restore_out <= 1'b0;
            upper_thr_out <= '0;
            lower_thr_out <= '0;
        end else begin
            active_bank_out <= bank_d;
            ext_teach_out <= (bank_eff != BANK_DEFAULT) & stable_q[1];
            sync_out <= sync_used & stable_q[2];
            sync_valid_out <= sync_used;
            bank_setting_out <= bank_eff;
            link_enable_out <= rate_code != 3'h0;
            monitor_enable_out <= rate_code == 3'h0;
            baud_rate_out <= (rate_code == 3'h0) ? 32'h0 : rate_of(rate_code);
            frame_data_bits_out <= 4'(DATA_BITS);
            frame_stop_bits_out <= 2'(STOP_BITS);
            measure_enable_out <= !transfer_q && menu_q != MENU_INIT;
            menu_state_out <= menu_q;
            commit_out <= set_long;
            auto_gain_out <= menu_q == MENU_AUTO;
            indicator_out <= (menu_q != MENU_AUTO) ? 2'h0 :
                (alt_cnt_q < 32'(ALT_COUNT) ? 2'h1 : 2'h2);
            factory_restore_out <= menu_q == MENU_INIT;
            if (teach_in && edge_mode_in) begin
                upper_thr_out <= taught_count_in;
                lower_thr_out <= taught_count_in;
            end else if (teach_in) begin
                upper_thr_out <= {3{measured_in + margin}};
                lower_thr_out <= {3{measured_in - margin}};
            end
        end
    end
endmodule
`default_nettype wire

// ==== bank_ctrl_checker.sv ====
// Port-level checker for the bank and input select block.
// Assumes it is bound to the block; a single clock domain.
`timescale 1ns/1ps
`default_nettype none
module bank_ctrl_checker
    import bank_ctrl_pkg::*;
#(
    parameter int HOLD_COUNT = 20,
    parameter int ALT_COUNT = 4
) (
    // Clock, reset and inputs
    input wire logic clock_in,
    input wire logic nrst_in,
    input wire logic [2:0] wired_in,
    input wire logic [3:0] bank_setting_in,
    input wire logic [2:0] trigger_select_in,
    input wire logic [2:0] serial_rate_select_in,
    input wire logic host_transfer_mode_in,
    input wire logic transfer_done_in,
    input wire logic set_key_in,
    // Outputs watched
    input wire logic [2:0] active_bank_out,
    input wire logic ext_teach_out,
    input wire logic link_enable_out,
    input wire logic monitor_enable_out,
    input wire logic [31:0] baud_rate_out,
    input wire logic [3:0] frame_data_bits_out,
    input wire logic [1:0] frame_stop_bits_out,
    input wire logic measure_enable_out,
    input wire logic commit_out,
    input wire logic auto_gain_out,
    input wire logic [1:0] indicator_out
);
    localparam int RT [6] = '{0, RATE_4800, RATE_9600, RATE_19200, RATE_38400, RATE_57600};
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (!nrst_in);
    int held_q;
    // Raw hold length of the set key
    always_ff @(posedge clock_in or negedge nrst_in) begin
        if (!nrst_in) held_q <= 0;
        else held_q <= set_key_in ? held_q + 1 : 0;
    end
    // Length of an unchanged indicator pattern while auto gain runs
    logic [1:0] ind_prev_q;
    int same_q;
    always_ff @(posedge clock_in or negedge nrst_in) begin
        if (!nrst_in) begin
            ind_prev_q <= 2'h0;
            same_q <= 0;
        end else begin
            ind_prev_q <= indicator_out;
            same_q <= (auto_gain_out && indicator_out == ind_prev_q) ? same_q + 1 : 0;
        end
    end
    a_frame_fixed: assert property (frame_data_bits_out == 4'h8 && frame_stop_bits_out == 2'h1)
        else $error("frame format wrong");
    a_direct_bank: assert property (bank_setting_in < 4'h8 |=> active_bank_out == $past(bank_setting_in[2:0]))
        else $error("direct bank not applied");
    a_rate_map: assert property (serial_rate_select_in <= 3'h5 |=> baud_rate_out == 32'(RT[$past(serial_rate_select_in)]))
        else $error("baud rate wrong");
    a_link_off: assert property (serial_rate_select_in == 3'h0 |=> !link_enable_out && monitor_enable_out)
        else $error("link not off at code zero");
    a_measure_stop: assert property (host_transfer_mode_in && !transfer_done_in |-> ##2 !measure_enable_out)
        else $error("measuring during transfer");
    a_teach_role: assert property (bank_setting_in == 4'h9 |=> !ext_teach_out)
        else $error("teach seen in bank role");
    a_sync_role: assert property (bank_setting_in == 4'h9 && trigger_select_in < 3'h4 |=> !active_bank_out[2])
        else $error("sync input used as bank bit");
    a_commit_hold: assert property (commit_out |-> held_q >= HOLD_COUNT)
        else $error("commit on short press");
    a_gain_blink: assert property (auto_gain_out && $past(auto_gain_out) |-> indicator_out == 2'h1 || indicator_out == 2'h2)
        else $error("indicators not alternating");
    a_blink_period: assert property (same_q <= ALT_COUNT)
        else $error("indicator pattern stuck during auto gain");
    a_bank_filter: assert property ($changed(active_bank_out) && $past(bank_setting_in) == 4'h9
        && $past(bank_setting_in, 2) == 4'h9 && $past(trigger_select_in) == $past(trigger_select_in, 2)
        |-> $past(wired_in, 5) == $past(wired_in, 12))
        else $error("bank followed unstable input");
    c_commit: cover property (commit_out);
    c_gain: cover property (auto_gain_out);
    c_transfer: cover property (host_transfer_mode_in && !measure_enable_out);
endmodule
`default_nettype wire

// ==== ext_ctrl_model.sv ====
// External controller on the wired inputs.
// Assumes the bench sets line levels and which lines are connected.
`timescale 1ns/1ps
`default_nettype none
module ext_ctrl_model (
    // Requested levels and connections
    input wire logic [2:0] level_in,
    input wire logic [2:0] connect_in,
    // Wired lines into the sensor
    output logic [2:0] wired_out
);
    // An open line reads as logic 0 at the sensor, bit 0 is input one
    assign wired_out = level_in & connect_in;
endmodule
`default_nettype wire

// ==== bank_input_select_control_tb.sv ====
// Self-checking bench for the bank and input select block.
// Assumes the checker and controller model files are compiled first.
`timescale 1ns/1ps
`default_nettype none
module bank_input_select_control_tb;
    import bank_ctrl_pkg::*;
    // Short hold count keeps long key presses cheap to simulate
    localparam int HOLD = 20;
    localparam int RT [6] = '{0, RATE_4800, RATE_9600, RATE_19200, RATE_38400, RATE_57600};
    logic clock_in = 1'h0, nrst_in = 1'h0;
    logic [2:0] wired_in, lvl = 3'h0, con = 3'h7;
    logic [3:0] bank_setting_in = 4'h9;
    logic [2:0] trigger_select_in = 3'h4, serial_rate_select_in = 3'h5;
    logic host_transfer_mode_in = 1'h0, transfer_done_in = 1'h0, oper_menu_in = 1'h0;
    logic exit_key_in = 1'h1, set_key_in = 1'h1, gain_done_in = 1'h0;
    logic teach_in = 1'h0, edge_mode_in = 1'h0, restored = 1'h0;
    logic [3:0] ind_seen = 4'h0;
    logic [47:0] taught_count_in = 48'h0003_0002_0001, upper_thr_out, lower_thr_out;
    logic [15:0] measured_in = 16'h03E8;
    logic [2:0] active_bank_out;
    logic ext_teach_out, sync_out, sync_valid_out, link_enable_out, monitor_enable_out;
    logic [3:0] bank_setting_out, frame_data_bits_out, menu_state_out;
    logic [31:0] baud_rate_out;
    logic [1:0] frame_stop_bits_out, indicator_out;
    logic measure_enable_out, commit_out, auto_gain_out, factory_restore_out;
    int error_cnt = 0, num_checks = 0, commits = 0;
    always #10 clock_in = ~clock_in;
    ext_ctrl_model ctrl_u (.level_in(lvl), .connect_in(con), .wired_out(wired_in));
    bank_input_select_control #(.HOLD_COUNT(HOLD), .ALT_COUNT(4)) dut_u (.*);
    always @(posedge clock_in) begin
        if (commit_out === 1'h1) commits++;
        if (factory_restore_out === 1'h1) restored = 1'h1;
    end
    task automatic chk(input logic [47:0] seen, input logic [47:0] exp);
        num_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[FAIL] %0t ns: got %0h want %0h", $time, seen, exp);
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge clock_in);
        #1;
    endtask
    task automatic bank_case(input logic [3:0] s, input logic [2:0] t, input logic [2:0] w,
        input logic [2:0] exp);
        bank_setting_in = s;
        trigger_select_in = t;
        lvl = w;
        step(30);
        chk(active_bank_out, exp);
    endtask
    task automatic teach();
        teach_in = 1'h1;
        step(1);
        teach_in = 1'h0;
        step(4);
    endtask
    task automatic complete_run();
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    initial begin
        #200000;
        error_cnt++;
        complete_run();
    end
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        step(4);
        nrst_in = 1'h1;
        step(12);
        chk(restored, 1'h1);
        set_key_in = 1'h0;
        exit_key_in = 1'h0;
        nrst_in = 1'h0;
        step(4);
        chk(baud_rate_out, 32'(RATE_57600));
        nrst_in = 1'h1;
        step(10);
        chk({frame_data_bits_out, frame_stop_bits_out}, 6'h21);
        for (int b = 0; b < 8; b++) bank_case(4'(b), 3'h4, 3'h7, 3'(b));
        bank_case(4'h8, 3'h4, 3'h7, 3'h5);
        chk(ext_teach_out, 1'h1);
        for (int w = 0; w < 8; w++) bank_case(4'h9, 3'h4, 3'(w), 3'(w));
        chk(ext_teach_out, 1'h0);
        bank_case(4'h9, 3'h0, 3'h7, 3'h3);
        chk({sync_valid_out, sync_out}, 2'h3);
        con = 3'h5;
        bank_case(4'h9, 3'h4, 3'h7, 3'h5);
        con = 3'h7;
        bank_case(4'h9, 3'h4, 3'h0, 3'h0);
        chk({sync_valid_out, sync_out}, 2'h0);
        lvl = 3'h7;
        step(5);
        lvl = 3'h0;
        step(30);
        chk(active_bank_out, 3'h0);
        bank_case(4'hC, 3'h4, 3'h0, 3'h0);
        chk(bank_setting_out, 4'h9);
        for (int r = 0; r < 6; r++) begin
            serial_rate_select_in = 3'(r);
            step(3);
            chk(baud_rate_out, 32'(RT[r]));
            chk({link_enable_out, monitor_enable_out}, (r != 0) ? 2'h2 : 2'h1);
        end
        host_transfer_mode_in = 1'h1;
        step(3);
        chk(measure_enable_out, 1'h0);
        transfer_done_in = 1'h1;
        host_transfer_mode_in = 1'h0;
        step(3);
        chk(measure_enable_out, 1'h1);
        transfer_done_in = 1'h0;
        set_key_in = 1'h1;
        step(HOLD / 2);
        set_key_in = 1'h0;
        step(10);
        chk(commits, 0);
        set_key_in = 1'h1;
        step(HOLD + 10);
        set_key_in = 1'h0;
        step(5);
        chk(commits, 1);
        exit_key_in = 1'h1;
        step(HOLD + 10);
        exit_key_in = 1'h0;
        repeat (8) begin
            step(1);
            ind_seen = ind_seen | (4'h1 << indicator_out);
        end
        chk({auto_gain_out, menu_state_out}, 5'h14);
        chk(ind_seen, 4'h6);
        gain_done_in = 1'h1;
        step(1);
        gain_done_in = 1'h0;
        step(5);
        chk(auto_gain_out, 1'h0);
        oper_menu_in = 1'h1;
        step(5);
        oper_menu_in = 1'h0;
        chk(menu_state_out, 4'h2);
        exit_key_in = 1'h1;
        step(4);
        exit_key_in = 1'h0;
        step(6);
        chk(menu_state_out, 4'h1);
        teach();
        chk(upper_thr_out, {3{16'h041A}});
        chk(lower_thr_out, {3{16'h03B6}});
        edge_mode_in = 1'h1;
        teach();
        chk(upper_thr_out, taught_count_in);
        chk(lower_thr_out, taught_count_in);
        complete_run();
    end
endmodule
bind bank_input_select_control bank_ctrl_checker #(
    .HOLD_COUNT(HOLD_COUNT),
    .ALT_COUNT(ALT_COUNT)
) chk_u (.*);
`default_nettype wire
